// >>> verilog/port_and_extint_clock_select.sv
// Chosen here: the AXI4-Lite register port.
`include "port_clk_defines.svh"

module port_and_extint_clock_select #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       warm_reset_n,
    input  wire logic                       ce,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0]          awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]          araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // port pins
    input  wire logic [7:0]                 port_pin_in,
    output logic [7:0]                      port_pin_out,
    output logic [7:0]                      port_pin_oe,
    // alternate functions
    input  wire logic                       timer_two_out,
    input  wire logic                       second_serial_transmit,
    output port_clk_pkg::alt_in_t           alt_in,
    // clock control
    input  wire logic                       crystal_warmed_status,
    input  wire logic                       crystal_disable,
    input  wire logic                       power_down_exit,
    output logic                            use_crystal_clock,
    output logic                            cpu_hold,
    // interrupt
    output logic                            irq
);
    // register state
    logic [7:0]                 port_latch;
    logic [7:0]                 next_port_latch;
    logic [7:0]                 pin_prev;
    logic [7:0]                 next_pin_prev;
    logic [3:0]                 ext_flags;
    logic [3:0]                 next_ext_flags;
    logic [3:0]                 irq_status;
    logic [3:0]                 next_irq_status;
    logic [3:0]                 irq_mask;
    logic [3:0]                 next_irq_mask;
    port_clk_pkg::clk_ctrl_t    clk_ctrl;
    port_clk_pkg::clk_ctrl_t    next_clk_ctrl;
    port_clk_pkg::pwr_state_t   pwr_state;
    port_clk_pkg::pwr_state_t   next_pwr_state;
    // bus state
    logic                       aw_held;
    logic                       next_aw_held;
    logic                       w_held;
    logic                       next_w_held;
    logic [ADDR_W-1:0]          wr_addr;
    logic [ADDR_W-1:0]          next_wr_addr;
    logic [7:0]                 wr_byte;
    logic [7:0]                 next_wr_byte;
    logic                       wr_lane;
    logic                       next_wr_lane;
    logic                       next_bvalid;
    logic [1:0]                 next_bresp;
    logic                       next_rvalid;
    logic [31:0]                next_rdata;
    logic [1:0]                 next_rresp;
    // decode helpers
    logic                       do_write;
    logic                       wr_port;
    logic                       wr_flags;
    logic                       wr_status;
    logic                       wr_mask;
    logic                       wr_ok;
    logic [3:0]                 edge_hit;
    logic [7:0]                 flags_view;
    logic                       ar_take;

    assign awready = ce && !aw_held && !bvalid;
    assign wready  = ce && !w_held && !bvalid;
    assign arready = ce && !rvalid;
    assign ar_take = arvalid && arready;
    assign do_write = ce && aw_held && w_held && !bvalid;

    // write address decode
    always_comb begin
        wr_port   = 1'b0;
        wr_flags  = 1'b0;
        wr_status = 1'b0;
        wr_mask   = 1'b0;
        wr_ok     = 1'b1;
        if (wr_addr == `REG_PORT_ADDR) begin
            wr_port = 1'b1;
        end else if (wr_addr == `REG_FLAGS_ADDR) begin
            wr_flags = 1'b1;
        end else if (wr_addr == `REG_LATCH_ADDR) begin
            wr_port = 1'b1;
        end else if (wr_addr == `REG_STATUS_ADDR) begin
            wr_status = 1'b1;
        end else if (wr_addr == `REG_MASK_ADDR) begin
            wr_mask = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // edge detection on the interrupt pins
    always_comb begin
        edge_hit[3] = pin_prev[7] && !port_pin_in[7]; // RULE_04
        edge_hit[2] = !pin_prev[6] && port_pin_in[6]; // RULE_05
        edge_hit[1] = pin_prev[5] && !port_pin_in[5]; // RULE_06
        edge_hit[0] = !pin_prev[4] && port_pin_in[4]; // RULE_07
    end

    assign flags_view = {ext_flags, clk_ctrl.clock_source_select,
                         clk_ctrl.rc_mode_status, clk_ctrl.resume_source_select,
                         1'b0}; // RULE_15

    // bus channel next state
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_wr_addr = wr_addr;
        next_wr_byte = wr_byte;
        next_wr_lane = wr_lane;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held  = 1'b1;
            next_wr_byte = wdata[7:0];
            next_wr_lane = wstrb[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (ce && bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (araddr == `REG_PORT_ADDR) begin
                next_rdata[7:0] = port_pin_in; // RULE_01
            end else if (araddr == `REG_FLAGS_ADDR) begin
                next_rdata[7:0] = flags_view;
            end else if (araddr == `REG_LATCH_ADDR) begin
                // read-modify-write software reads this view
                next_rdata[7:0] = port_latch; // RULE_02
            end else if (araddr == `REG_STATUS_ADDR) begin
                next_rdata[3:0] = irq_status;
            end else if (araddr == `REG_MASK_ADDR) begin
                next_rdata[3:0] = irq_mask;
            end else begin
                next_rresp = `RESP_SLVERR;
            end
        end else if (ce && rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr_addr <= '0;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else if (ce) begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_byte <= next_wr_byte;
            wr_lane <= next_wr_lane;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // port, flags and interrupt next state
    always_comb begin
        next_port_latch = port_latch;
        next_pin_prev   = port_pin_in;
        next_ext_flags  = ext_flags;
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (do_write && wr_lane && wr_port) begin
            next_port_latch = wr_byte;
        end
        if (do_write && wr_lane && wr_flags) begin
            // a written 0 clears, a written 1 leaves the flag alone
            next_ext_flags = ext_flags & wr_byte[7:4]; // RULE_15
        end
        if (do_write && wr_lane && wr_status) begin
            next_irq_status = irq_status & ~wr_byte[3:0];
        end
        if (do_write && wr_lane && wr_mask) begin
            next_irq_mask = wr_byte[3:0];
        end
        // a new edge wins over a clear in the same cycle
        next_ext_flags  = next_ext_flags | edge_hit; // RULE_04 RULE_05 RULE_06 RULE_07
        next_irq_status = next_irq_status | edge_hit;
    end

    // warm reset restores port and flags but not clock control
    always_ff @(posedge aclk) begin
        if (!aresetn || !warm_reset_n) begin
            port_latch <= `PORT_RESET;
            pin_prev   <= `PORT_RESET;
            ext_flags  <= 4'h0;
            irq_status <= 4'h0;
            irq_mask   <= 4'h0;
        end else if (ce) begin
            port_latch <= next_port_latch;
            pin_prev   <= next_pin_prev;
            ext_flags  <= next_ext_flags;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    // clock source control
    always_comb begin
        next_clk_ctrl  = clk_ctrl;
        next_pwr_state = pwr_state;
        if (do_write && wr_lane && wr_flags) begin
            next_clk_ctrl.resume_source_select = wr_byte[`RESUME_SEL_BIT];
            if (!wr_byte[`CLK_SEL_BIT]) begin
                next_clk_ctrl.clock_source_select = 1'b0; // RULE_08
            end else if (crystal_warmed_status && !crystal_disable) begin
                next_clk_ctrl.clock_source_select = 1'b1; // RULE_09
            end
        end
        case (pwr_state)
            port_clk_pkg::ST_RUN: begin
                if (power_down_exit) begin
                    if (clk_ctrl.resume_source_select) begin
                        next_clk_ctrl.clock_source_select = 1'b0; // RULE_13
                    end else begin
                        next_pwr_state = port_clk_pkg::ST_HOLD_WARM; // RULE_14
                    end
                end
            end
            port_clk_pkg::ST_HOLD_WARM: begin
                if (crystal_warmed_status) begin
                    next_pwr_state = port_clk_pkg::ST_RUN; // RULE_14
                end
            end
            default: begin
                next_pwr_state = port_clk_pkg::ST_RUN;
            end
        endcase
        next_clk_ctrl.rc_mode_status = !next_clk_ctrl.clock_source_select; // RULE_11
    end

    // only power-on reset touches these; warm reset deliberately ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_ctrl.clock_source_select  <= `CLK_SEL_POR; // RULE_10
            clk_ctrl.rc_mode_status       <= `RC_MODE_POR; // RULE_12
            clk_ctrl.resume_source_select <= `RESUME_SEL_POR; // RULE_12
            pwr_state                     <= port_clk_pkg::ST_RUN;
        end else if (ce) begin
            clk_ctrl  <= next_clk_ctrl;
            pwr_state <= next_pwr_state;
        end
    end

    // pins: open-drain style, alternate outputs ANDed with the latch
    always_comb begin
        port_pin_out    = 8'h00;
        port_pin_oe     = ~port_latch;
        port_pin_oe[0]  = !(port_latch[0] && timer_two_out); // RULE_03
        port_pin_oe[3]  = !(port_latch[3] && second_serial_transmit); // RULE_03
    end

    assign alt_in.timer_two_ext_io          = port_pin_in[0]; // RULE_03
    assign alt_in.timer_two_capture_trigger = port_pin_in[1]; // RULE_03
    assign alt_in.second_serial_receive     = port_pin_in[2]; // RULE_03
    assign use_crystal_clock = clk_ctrl.clock_source_select; // RULE_08
    assign cpu_hold = (pwr_state == port_clk_pkg::ST_HOLD_WARM);
    assign irq = |(irq_status & irq_mask);

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_flag_write;
        ce && do_write && wr_lane && wr_flags;
    endsequence

    sequence s_read_at(logic [ADDR_W-1:0] a);
        ce && ar_take && araddr == a;
    endsequence

    AST_PORT_READS_PINS: assert property ( // RULE_01
        s_read_at(`REG_PORT_ADDR) |=> rdata[7:0] == $past(port_pin_in))
        else $error("port read did not return pin levels");
    AST_LATCH_VIEW: assert property ( // RULE_02
        s_read_at(`REG_LATCH_ADDR) |=> rdata[7:0] == $past(port_latch))
        else $error("latch view did not return latch");
    AST_IRQ5_FALL: assert property ( // RULE_04
        ce && warm_reset_n && pin_prev[7] && !port_pin_in[7] |=> ext_flags[3])
        else $error("falling edge on irq 5 not flagged");
    AST_IRQ4_RISE: assert property ( // RULE_05
        ce && warm_reset_n && !pin_prev[6] && port_pin_in[6] |=> ext_flags[2])
        else $error("rising edge on irq 4 not flagged");
    AST_IRQ3_FALL: assert property ( // RULE_06
        ce && warm_reset_n && pin_prev[5] && !port_pin_in[5] |=> ext_flags[1])
        else $error("falling edge on irq 3 not flagged");
    AST_IRQ2_RISE: assert property ( // RULE_07
        ce && warm_reset_n && !pin_prev[4] && port_pin_in[4] |=> ext_flags[0])
        else $error("rising edge on irq 2 not flagged");
    AST_SET_GUARDED: assert property ( // RULE_09
        s_flag_write ##0 (!clk_ctrl.clock_source_select && wr_byte[`CLK_SEL_BIT]
        && (!crystal_warmed_status || crystal_disable) && !power_down_exit)
        |=> !clk_ctrl.clock_source_select)
        else $error("clock select set without warm crystal");
    AST_WARM_KEEPS_CLK: assert property ( // RULE_10
        ce && !warm_reset_n && !do_write && !power_down_exit |=> $stable(clk_ctrl))
        else $error("warm reset changed clock control");
    AST_RC_STATUS: assert property ( // RULE_11
        clk_ctrl.rc_mode_status == !use_crystal_clock)
        else $error("rc status disagrees with clock source");
    AST_RESUME_RC: assert property ( // RULE_13
        ce && power_down_exit && !cpu_hold && clk_ctrl.resume_source_select
        |=> !use_crystal_clock && !cpu_hold)
        else $error("resume did not switch to rc");
    AST_RESUME_HOLD: assert property ( // RULE_14
        ce && power_down_exit && !cpu_hold && !clk_ctrl.resume_source_select
        |=> cpu_hold)
        else $error("resume did not hold for crystal");
    AST_FLAG_STICKY: assert property ( // RULE_15
        ce && warm_reset_n && ext_flags[3] && !(do_write && wr_flags) |=> ext_flags[3])
        else $error("flag dropped without a clear");
    AST_BIT0_ZERO: assert property ( // RULE_15
        s_read_at(`REG_FLAGS_ADDR) |=> rdata[0] == 1'b0)
        else $error("flag register bit 0 not zero");

endmodule

// >>> inc/port_clk_defines.svh
`ifndef PORT_CLK_DEFINES_SVH
`define PORT_CLK_DEFINES_SVH
// Notes on behaviour
// [RULE_01] A normal read of the port register returns the levels on the eight pins.
// [RULE_02] A read-modify-write read of the port returns the output latch instead.
// [RULE_03] Port bits 0..7 carry timer 2 io, timer 2 trigger, serial rx/tx, ext irqs 2..5.
// [RULE_04] A falling edge on the irq 5 input sets flag bit 7.
// [RULE_05] A rising edge on the irq 4 input sets flag bit 6.
// [RULE_06] A falling edge on the active-low irq 3 input sets flag bit 5.
// [RULE_07] A rising edge on the irq 2 input sets flag bit 4.
// [RULE_08] Bit 3 set selects the crystal clock, cleared selects the on-chip RC oscillator.
// [RULE_09] Setting bit 3 is ignored unless the crystal is warmed up and not disabled.
// [RULE_10] Power-on reset sets bit 3; other resets leave it alone.
// [RULE_11] Bit 2 reads 1 while running from RC, 0 while running from the crystal.
// [RULE_12] Power-on reset clears bits 2 and 1; other resets leave them alone.
// [RULE_13] With bit 1 set the device resumes from power-down on the RC oscillator.
// [RULE_14] With bit 1 clear the device holds after power-down until the crystal is warm.
// [RULE_15] Flags stay set until software writes 0 to them; bit 0 always reads 0.

// register indices; byte address is four times the index
`define REG_PORT_IDX    8'h90
`define REG_FLAGS_IDX   8'h91
`define REG_PORT_ADDR   {2'b00, `REG_PORT_IDX, 2'b00}
`define REG_FLAGS_ADDR  {2'b00, `REG_FLAGS_IDX, 2'b00}
`define REG_LATCH_ADDR  12'h248
`define REG_STATUS_ADDR 12'h24c
`define REG_MASK_ADDR   12'h250

`define FLAG_IRQ5_BIT   7
`define FLAG_IRQ4_BIT   6
`define FLAG_IRQ3_BIT   5
`define FLAG_IRQ2_BIT   4
`define CLK_SEL_BIT     3
`define RC_MODE_BIT     2
`define RESUME_SEL_BIT  1

`define PORT_RESET      8'hff
`define CLK_SEL_POR     1'b1
`define RC_MODE_POR     1'b0
`define RESUME_SEL_POR  1'b0
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// >>> inc/port_clk_pkg.sv
package port_clk_pkg;
    typedef struct packed {
        logic clock_source_select;
        logic rc_mode_status;
        logic resume_source_select;
    } clk_ctrl_t;

    typedef struct packed {
        logic timer_two_ext_io;
        logic timer_two_capture_trigger;
        logic second_serial_receive;
    } alt_in_t;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b01,
        ST_HOLD_WARM = 2'b10
    } pwr_state_t;
endpackage

// >>> verification/pin_partner.sv
module pin_partner #(
    parameter int WARM_CYC = 20
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // port pins
    input  wire logic [7:0] port_pin_out,
    input  wire logic [7:0] port_pin_oe,
    input  wire logic [7:0] ext_low,
    output logic      [7:0] pin_level,
    // crystal
    input  wire logic       xtal_restart,
    output logic            crystal_warmed_status
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt;

    // open drain with pull-up: a released pin reads high unless ext_low pulls it low, never the old level
    assign pin_level = ~((port_pin_oe & ~port_pin_out) | ext_low);
    assign crystal_warmed_status = (cnt >= WARM_CYC);

    // restart models leaving power-down: the crystal needs time again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= WARM_CYC;
        end else if (xtal_restart) begin
            cnt <= 0;
        end else if (cnt < WARM_CYC) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> verification/port_and_extint_clock_select_bench.sv
`include "port_clk_defines.svh"

module port_and_extint_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_PORT  = `REG_PORT_ADDR;
    localparam logic [11:0] A_FLAGS = `REG_FLAGS_ADDR;
    localparam logic [11:0] A_LATCH = `REG_LATCH_ADDR;
    localparam logic [11:0] A_STAT  = `REG_STATUS_ADDR;
    localparam logic [11:0] A_MASK  = `REG_MASK_ADDR;

    logic                  aclk;
    logic                  aresetn;
    logic                  warm_reset_n;
    logic                  ce;
    logic [11:0]           awaddr;
    logic                  awvalid;
    logic                  awready;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  bready;
    logic [11:0]           araddr;
    logic                  arvalid;
    logic                  arready;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic                  rready;
    logic [7:0]            pin_level;
    logic [7:0]            port_pin_out;
    logic [7:0]            port_pin_oe;
    logic [7:0]            ext_low;
    logic                  timer_two_out;
    logic                  second_serial_transmit;
    port_clk_pkg::alt_in_t alt_in;
    logic                  crystal_warmed_status;
    logic                  crystal_disable;
    logic                  xtal_restart;
    logic                  power_down_exit;
    logic                  use_crystal_clock;
    logic                  cpu_hold;
    logic                  irq;
    int                    n_fail;
    int                    cmp_count;

    port_and_extint_clock_select dut (
        .aclk(aclk), .aresetn(aresetn), .warm_reset_n(warm_reset_n), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .port_pin_in(pin_level), .port_pin_out(port_pin_out),
        .port_pin_oe(port_pin_oe), .timer_two_out(timer_two_out),
        .second_serial_transmit(second_serial_transmit), .alt_in(alt_in),
        .crystal_warmed_status(crystal_warmed_status),
        .crystal_disable(crystal_disable), .power_down_exit(power_down_exit),
        .use_crystal_clock(use_crystal_clock), .cpu_hold(cpu_hold), .irq(irq)
    );

    pin_partner #(.WARM_CYC(20)) far_side (
        .aclk(aclk), .aresetn(aresetn), .port_pin_out(port_pin_out),
        .port_pin_oe(port_pin_oe), .ext_low(ext_low), .pin_level(pin_level),
        .xtal_restart(xtal_restart), .crystal_warmed_status(crystal_warmed_status)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // +1ns so outputs updated at the edge have landed
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // each bus task starts at an edge so a strobe is never driven twice in one step
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
            n++;
            if (n > 50) begin
                n_fail++;
                close_out();
            end
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
            n++;
            if (n > 50) begin
                n_fail++;
                close_out();
            end
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        bus_wr(a, d, r);
        check(r, `RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        bus_rd(a, d, r);
        check(r, `RESP_OKAY);
        check(d, exp);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n_fail = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        warm_reset_n = 1'b1;
        ce = 1'b1;
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'h1;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
        ext_low = 8'h00;
        timer_two_out = 1'b1;
        second_serial_transmit = 1'b1;
        crystal_disable = 1'b0;
        xtal_restart = 1'b0;
        power_down_exit = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(A_FLAGS, 32'h0000_0008);
        check(use_crystal_clock, 32'h1);
        // latch differs from pins so the two read paths can be told apart
        wr(A_LATCH, 8'h5a);
        ext_low <= 8'h02;
        rd_chk(A_PORT, 32'h0000_0058);
        rd_chk(A_LATCH, 32'h0000_005a);
        ext_low <= 8'h00;
        wr(A_PORT, 8'hff);
        timer_two_out <= 1'b0;
        second_serial_transmit <= 1'b0;
        tick(1);
        check(port_pin_oe, 32'h09);
        rd_chk(A_PORT, 32'h0000_00f6);
        check(alt_in, 32'h3);
        timer_two_out <= 1'b1;
        second_serial_transmit <= 1'b1;
        // odd bits react to falling edges, even bits to rising edges
        for (int i = 4; i < 8; i++) begin
            wr(A_FLAGS, 8'h08);
            ext_low[i] <= 1'b1;
            tick(3);
            rd_chk(A_FLAGS, 32'h08 | ((i % 2) ? (32'h1 << i) : 32'h0));
            ext_low[i] <= 1'b0;
            tick(3);
            rd_chk(A_FLAGS, 32'h08 | (32'h1 << i));
        end
        rd_chk(A_STAT, 32'h0000_000f);
        check(irq, 32'h0);
        wr(A_MASK, 8'h04);
        tick(1);
        check(irq, 32'h1);
        wr(A_STAT, 8'h04);
        tick(1);
        check(irq, 32'h0);
        rd_chk(A_STAT, 32'h0000_000b);
        wr(A_FLAGS, 8'h89);
        rd_chk(A_FLAGS, 32'h0000_0088);
        wr(A_FLAGS, 8'h08);
        rd_chk(A_FLAGS, 32'h0000_0008);
        wr(A_FLAGS, 8'h00);
        rd_chk(A_FLAGS, 32'h0000_0004);
        check(use_crystal_clock, 32'h0);
        crystal_disable <= 1'b1;
        wr(A_FLAGS, 8'h08);
        rd_chk(A_FLAGS, 32'h0000_0004);
        crystal_disable <= 1'b0;
        xtal_restart <= 1'b1;
        @(posedge aclk);
        xtal_restart <= 1'b0;
        wr(A_FLAGS, 8'h08);
        rd_chk(A_FLAGS, 32'h0000_0004);
        tick(25);
        wr(A_FLAGS, 8'h08);
        rd_chk(A_FLAGS, 32'h0000_0008);
        check(use_crystal_clock, 32'h1);
        wr(A_FLAGS, 8'h0a);
        power_down_exit <= 1'b1;
        @(posedge aclk);
        power_down_exit <= 1'b0;
        tick(1);
        check(use_crystal_clock, 32'h0);
        rd_chk(A_FLAGS, 32'h0000_0006);
        wr(A_FLAGS, 8'h08);
        xtal_restart <= 1'b1;
        @(posedge aclk);
        xtal_restart <= 1'b0;
        power_down_exit <= 1'b1;
        @(posedge aclk);
        power_down_exit <= 1'b0;
        tick(2);
        check(cpu_hold, 32'h1);
        n = 0;
        while (cpu_hold === 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        if (n >= 60) begin
            n_fail++;
            close_out();
        end
        check(crystal_warmed_status, 32'h1);
        wr(A_FLAGS, 8'h02);
        wr(A_LATCH, 8'hfe);
        warm_reset_n <= 1'b0;
        @(posedge aclk);
        warm_reset_n <= 1'b1;
        rd_chk(A_FLAGS, 32'h0000_0006);
        rd_chk(A_LATCH, 32'h0000_00ff);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(A_FLAGS, 32'h0000_0008);
        check(use_crystal_clock, 32'h1);
        bus_rd(12'h300, d, r);
        check(r, `RESP_SLVERR);
        check(d, 32'h0000_0000);
        bus_wr(12'h300, 8'h55, r);
        check(r, `RESP_SLVERR);
        close_out();
    end
endmodule
